// file: verilog/sptc_serial_ctrl.sv
// Purpose: serial port control register, transmit scheduling, pin ownership
// Assumes: APB slave, answers in the first access cycle
// Notes: baud divisor 0 stops both bit clocks
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sptc_serial_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic txd_i,
  output logic txd_o,
  output logic txd_oe,
  input wire logic rxd_i,
  output logic txd_pin_owned,
  output logic rxd_pin_owned,
  output logic irq
);
  typedef struct packed {
    sptc_pkg::sptc_ctrl2_type ctrl2;
    sptc_pkg::sptc_ctrl1_type ctrl1;
    logic [12:0] baud;
    sptc_pkg::sptc_flags_type flags;
    logic [8:0] txbuf;
    logic [8:0] rxbuf;
    logic break_pend;
    logic idle_pend;
    logic [12:0] ovs_cnt;
    logic [3:0] ovs_ph;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic tx_own;
    logic rx_own;
    logic txd_o;
    logic txd_oe;
  } sptc_state_type;
  sptc_state_type s_r;
  sptc_state_type s_nxt;

  // ----------------------------------------------------------------
  // bit clocks
  // ----------------------------------------------------------------
  logic s_tick;
  logic bit_tick;
  assign s_tick = (s_r.baud != 13'h0000) && (s_r.ovs_cnt == s_r.baud - 13'h0001);
  assign bit_tick = s_tick && (s_r.ovs_ph == sptc_pkg::OVS_LAST);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic setup;
  logic access;
  logic page_ok;
  logic [7:0] idx;
  logic hit;
  logic wr;
  logic rd;
  assign setup = psel && !penable;
  assign access = psel && penable && s_r.pready;
  assign page_ok = (paddr[15:10] == sptc_pkg::PAGE_BLK ||
                    paddr[15:10] == sptc_pkg::PAGE_NBLK) && paddr[1:0] == 2'b00;
  assign idx = paddr[9:2];
  assign hit = page_ok && (idx == sptc_pkg::IDX_BAUD || idx == sptc_pkg::IDX_CTRL1 ||
               idx == sptc_pkg::IDX_CTRL2 || idx == sptc_pkg::IDX_STAT ||
               idx == sptc_pkg::IDX_DATA);
  assign wr = access && pwrite && hit;
  assign rd = access && !pwrite && hit;

  // ----------------------------------------------------------------
  // transmitter and receiver
  // ----------------------------------------------------------------
  sptc_pkg::sptc_tx_cmd_type cmd;
  logic tx_accept;
  logic tx_busy;
  logic tx_line;
  logic rx_line;
  logic rx_done;
  logic [8:0] rx_data;
  logic rx_idle;
  logic single_wire;
  logic nine;
  logic [3:0] char_len;
  logic sbk_live;
  logic pick_break;
  logic pick_idle;

  assign nine = s_r.ctrl1.nine_bit_sel;
  assign char_len = sptc_pkg::CHAR_BITS + {3'h0, nine};
  assign single_wire = s_r.ctrl1.loopback_sel && s_r.ctrl1.rx_source_sel;
  assign sbk_live = s_r.ctrl2.break_queue && s_r.ctrl2.tx_on;
  assign pick_break = s_r.break_pend || sbk_live;
  assign pick_idle = !pick_break && s_r.idle_pend;

  always_comb
  begin
    cmd.go = pick_break || s_r.idle_pend || !s_r.flags.tx_buf_empty_flag;
    cmd.nbits = char_len;
    cmd.frame = nine ? {3'h7, 1'b1, s_r.txbuf, 1'b0} : {4'hf, 1'b1, s_r.txbuf[7:0], 1'b0};
    if (pick_break)
    begin
      cmd.frame = sptc_pkg::FRAME_BREAK;
      if (s_r.ctrl1.long_break_sel)
        cmd.nbits = sptc_pkg::BRK_LONG_BITS + {3'h0, nine};
    end
    else if (pick_idle)
      cmd.frame = sptc_pkg::FRAME_IDLE;
  end

  sptc_tx_shift u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .bit_tick(bit_tick),
    .cmd(cmd),
    .accept(tx_accept),
    .busy(tx_busy),
    .txd(tx_line)
  );

  // receiver source follows loopback and single-wire selection
  always_comb
  begin
    rx_line = rxd_i;
    if (single_wire)
      rx_line = s_r.ctrl1.single_line_dir ? tx_line : txd_i;
    else if (s_r.ctrl1.loopback_sel)
      rx_line = tx_line;
  end

  sptc_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .s_tick(s_tick),
    .line(rx_line),
    .enable(s_r.ctrl2.rx_on),
    .nine_bit(nine),
    .done(rx_done),
    .data(rx_data),
    .idle_hit(rx_idle)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  sptc_pkg::sptc_ctrl2_type wctl;
  logic wake;
  logic take_char;
  logic tx_own;
  assign wctl = pwdata[7:0];
  // address mark is the top data bit of the character in either length
  assign wake = s_r.ctrl2.rx_standby &&
                (s_r.ctrl1.wake_sel ? (rx_done && (nine ? rx_data[8] : rx_data[7]))
                                    : rx_idle);
  assign take_char = rx_done && (!s_r.ctrl2.rx_standby || wake);
  assign tx_own = s_r.ctrl2.tx_on || tx_busy || s_r.break_pend || s_r.idle_pend ||
                  !s_r.flags.tx_buf_empty_flag;

  always_comb
  begin
    s_nxt = s_r;
    // oversample divider and bit phase
    if (s_r.baud == 13'h0000 || s_tick)
      s_nxt.ovs_cnt = 13'h0000;
    else
      s_nxt.ovs_cnt = s_r.ovs_cnt + 13'h0001;
    if (s_tick)
      s_nxt.ovs_ph = s_r.ovs_ph + 4'h1;
    // transmit hand-off
    if (tx_accept)
    begin
      if (pick_break)
        s_nxt.break_pend = 1'b0;
      else if (pick_idle)
        s_nxt.idle_pend = 1'b0;
      else
        s_nxt.flags.tx_buf_empty_flag = 1'b1;
    end
    // receive side
    if (wake)
      s_nxt.ctrl2.rx_standby = 1'b0;
    if (rd && idx == sptc_pkg::IDX_DATA)
    begin
      s_nxt.flags.rx_buf_full_flag = 1'b0;
      s_nxt.flags.idle_flag = 1'b0;
    end
    if (take_char)
    begin
      s_nxt.rxbuf = rx_data;
      s_nxt.flags.rx_buf_full_flag = 1'b1;
    end
    if (rx_idle && !s_r.ctrl2.rx_standby)
      s_nxt.flags.idle_flag = 1'b1;
    // register writes
    if (wr)
    begin
      if (idx == sptc_pkg::IDX_BAUD)
        s_nxt.baud = pwdata[12:0];
      else if (idx == sptc_pkg::IDX_CTRL1)
        s_nxt.ctrl1 = pwdata[5:0];
      else if (idx == sptc_pkg::IDX_CTRL2)
      begin
        s_nxt.ctrl2 = wctl;
        if (wctl.rx_standby == 1'b0 && wake)
          s_nxt.ctrl2.rx_standby = 1'b0;
        if (wctl.tx_on && !s_r.ctrl2.tx_on)
          s_nxt.idle_pend = 1'b1;
        if (wctl.break_queue && !s_r.ctrl2.break_queue && wctl.tx_on)
          s_nxt.break_pend = 1'b1;
      end
      else if (idx == sptc_pkg::IDX_DATA)
      begin
        s_nxt.txbuf = pwdata[8:0];
        s_nxt.flags.tx_buf_empty_flag = 1'b0;
      end
    end
    // complete once nothing is queued or on the line
    s_nxt.flags.tx_idle_flag = s_nxt.flags.tx_buf_empty_flag && !tx_busy && !tx_accept &&
                               !s_nxt.break_pend && !s_nxt.idle_pend && !sbk_live;
    // bus answer
    s_nxt.pready = setup;
    s_nxt.pslverr = setup && !hit;
    if (setup)
    begin
      s_nxt.prdata = 32'h0000_0000;
      if (!page_ok)
        s_nxt.prdata = 32'h0000_0000;
      else if (idx == sptc_pkg::IDX_BAUD)
        s_nxt.prdata = {19'h00000, s_r.baud};
      else if (idx == sptc_pkg::IDX_CTRL1)
        s_nxt.prdata = {26'h0000000, s_r.ctrl1};
      else if (idx == sptc_pkg::IDX_CTRL2)
        s_nxt.prdata = {24'h000000, s_r.ctrl2};
      else if (idx == sptc_pkg::IDX_STAT)
        s_nxt.prdata = {24'h000000, s_r.flags, 4'h0};
      else if (idx == sptc_pkg::IDX_DATA)
        s_nxt.prdata = {23'h000000, s_r.rxbuf};
    end
    // interrupt and pins
    s_nxt.irq = (s_r.flags.tx_buf_empty_flag && s_r.ctrl2.tx_empty_irq_en) ||
                (s_r.flags.tx_idle_flag && s_r.ctrl2.tx_done_irq_en) ||
                (s_r.flags.rx_buf_full_flag && s_r.ctrl2.rx_full_irq_en) ||
                (s_r.flags.idle_flag && s_r.ctrl2.idle_irq_en);
    s_nxt.tx_own = tx_own;
    s_nxt.rx_own = s_r.ctrl2.rx_on && !s_r.ctrl1.loopback_sel;
    s_nxt.txd_o = tx_line;
    s_nxt.txd_oe = tx_own && (!single_wire || s_r.ctrl1.single_line_dir);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '{ctrl2: sptc_pkg::CTRL2_RST, ctrl1: sptc_pkg::CTRL1_RST,
               baud: sptc_pkg::BAUD_RST, flags: sptc_pkg::FLAGS_RST,
               txbuf: 9'h000, rxbuf: 9'h000, break_pend: 1'b0, idle_pend: 1'b0,
               ovs_cnt: 13'h0000, ovs_ph: 4'h0, prdata: 32'h0000_0000,
               pready: 1'b0, pslverr: 1'b0, irq: 1'b0, tx_own: 1'b0,
               rx_own: 1'b0, txd_o: 1'b1, txd_oe: 1'b0};
    else
      s_r <= s_nxt;
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign irq = s_r.irq;
  assign txd_o = s_r.txd_o;
  assign txd_oe = s_r.txd_oe;
  assign txd_pin_owned = s_r.tx_own;
  assign rxd_pin_owned = s_r.rx_own;
endmodule
`default_nettype wire

// file: pkg/sptc_pkg.sv
// Purpose: constants and types shared by the serial port control block
// Assumes: 32-bit APB, one aligned word per register, byte address = 4 * index
// Notes: each register answers in two pages of the index space
package sptc_pkg;
  // pages select blocking and non-blocking access to the same registers
  localparam logic [5:0] PAGE_BLK = 6'h0e;
  localparam logic [5:0] PAGE_NBLK = 6'h0f;
  localparam logic [7:0] IDX_BAUD = 8'h18;
  localparam logic [7:0] IDX_CTRL1 = 8'h1a;
  localparam logic [7:0] IDX_CTRL2 = 8'h1b;
  localparam logic [7:0] IDX_STAT = 8'h1c;
  localparam logic [7:0] IDX_DATA = 8'h1f;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [5:0] CTRL1_RST = 6'h00;
  localparam logic [12:0] BAUD_RST = 13'h0004;
  localparam logic [3:0] FLAGS_RST = 4'hc;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] RX_MID = 4'h7;
  localparam logic [3:0] CHAR_BITS = 4'ha;
  localparam logic [3:0] BRK_LONG_BITS = 4'hd;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [13:0] FRAME_IDLE = 14'h3fff;
  localparam logic [13:0] FRAME_BREAK = 14'h0000;

  typedef struct packed {
    logic tx_empty_irq_en;
    logic tx_done_irq_en;
    logic rx_full_irq_en;
    logic idle_irq_en;
    logic tx_on;
    logic rx_on;
    logic rx_standby;
    logic break_queue;
  } sptc_ctrl2_type;

  typedef struct packed {
    logic loopback_sel;
    logic single_line_dir;
    logic rx_source_sel;
    logic nine_bit_sel;
    logic wake_sel;
    logic long_break_sel;
  } sptc_ctrl1_type;

  typedef struct packed {
    logic tx_buf_empty_flag;
    logic tx_idle_flag;
    logic rx_buf_full_flag;
    logic idle_flag;
  } sptc_flags_type;

  typedef struct packed {
    logic go;
    logic [13:0] frame;
    logic [3:0] nbits;
  } sptc_tx_cmd_type;
endpackage

// file: verilog/sptc_tx_shift.sv
// Purpose: bit-timed line shifter for data, idle and break frames
// Assumes: bit_tick is a one-cycle pulse once per bit time
// Notes: a frame is loaded only on a bit tick so every bit is full length
`timescale 1ns/1ps
`default_nettype none
module sptc_tx_shift (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bit_tick,
  input wire sptc_pkg::sptc_tx_cmd_type cmd,
  output logic accept,
  output logic busy,
  output logic txd
);
  typedef struct packed {
    logic [13:0] frame;
    logic [3:0] left;
    logic line;
  } sptc_txs_type;
  sptc_txs_type s_r;
  sptc_txs_type s_nxt;

  // a queued frame starts as the last bit of the previous one ends, so repeated
  // breaks stay low with no mark bit between them
  assign accept = bit_tick & cmd.go & (s_r.left <= 4'h1);
  assign busy = (s_r.left != 4'h0);
  assign txd = s_r.line;

  always_comb
  begin
    s_nxt = s_r;
    if (accept)
    begin
      s_nxt.line = cmd.frame[0];
      s_nxt.frame = {1'b1, cmd.frame[13:1]};
      s_nxt.left = cmd.nbits;
    end
    else if (bit_tick && busy)
    begin
      s_nxt.left = s_r.left - 4'h1;
      // back to mark level once the last bit time is over
      s_nxt.line = (s_r.left == 4'h1) ? 1'b1 : s_r.frame[0];
      s_nxt.frame = {1'b1, s_r.frame[13:1]};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '{frame: 14'h3fff, left: 4'h0, line: 1'b1};
    else
      s_r <= s_nxt;
  end
endmodule
`default_nettype wire

// file: verilog/sptc_rx.sv
// Purpose: oversampling receiver with idle line detection
// Assumes: s_tick pulses sixteen times per bit time
// Notes: idle is reported once per burst of activity
`timescale 1ns/1ps
`default_nettype none
module sptc_rx (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic s_tick,
  input wire logic line,
  input wire logic enable,
  input wire logic nine_bit,
  output logic done,
  output logic [8:0] data,
  output logic idle_hit
);
  typedef enum logic [1:0] {RX_WAIT, RX_START, RX_BITS} sptc_rx_state_type;
  typedef struct packed {
    sptc_rx_state_type st;
    logic [3:0] sub;
    logic [3:0] nbit;
    logic [8:0] sh;
    logic [7:0] idle_cnt;
    logic active;
    logic done;
    logic idle_hit;
  } sptc_rxs_type;
  sptc_rxs_type s_r;
  sptc_rxs_type s_nxt;
  logic [3:0] nbits_data;
  logic [7:0] idle_len;

  assign nbits_data = sptc_pkg::DATA_BITS + {3'h0, nine_bit};
  assign idle_len = {sptc_pkg::CHAR_BITS + {3'h0, nine_bit}, 4'h0};
  assign done = s_r.done;
  assign idle_hit = s_r.idle_hit;
  assign data = nine_bit ? s_r.sh : {1'b0, s_r.sh[8:1]};

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.idle_hit = 1'b0;
    if (!enable)
    begin
      s_nxt.st = RX_WAIT;
      s_nxt.idle_cnt = 8'h00;
    end
    else if (s_tick)
    begin
      // idle counts ticks of continuous mark level
      if (!line)
        s_nxt.idle_cnt = 8'h00;
      else if (s_r.idle_cnt != idle_len)
        s_nxt.idle_cnt = s_r.idle_cnt + 8'h01;
      if (line && s_r.idle_cnt == idle_len - 8'h01 && s_r.active)
      begin
        s_nxt.idle_hit = 1'b1;
        s_nxt.active = 1'b0;
      end
      case (s_r.st)
        RX_WAIT:
          if (!line)
          begin
            s_nxt.st = RX_START;
            s_nxt.sub = 4'h0;
          end
        RX_START:
        begin
          s_nxt.sub = s_r.sub + 4'h1;
          if (s_r.sub == sptc_pkg::RX_MID)
          begin
            s_nxt.st = line ? RX_WAIT : RX_BITS;
            s_nxt.sub = 4'h0;
            s_nxt.nbit = 4'h0;
          end
        end
        default:
        begin
          s_nxt.sub = s_r.sub + 4'h1;
          if (s_r.sub == sptc_pkg::OVS_LAST)
          begin
            s_nxt.nbit = s_r.nbit + 4'h1;
            if (s_r.nbit == nbits_data)
            begin
              s_nxt.st = RX_WAIT;
              s_nxt.done = 1'b1;
              s_nxt.active = 1'b1;
            end
            else
              s_nxt.sh = {line, s_r.sh[8:1]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '{st: RX_WAIT, sub: 4'h0, nbit: 4'h0, sh: 9'h000, idle_cnt: 8'h00,
               active: 1'b0, done: 1'b0, idle_hit: 1'b0};
    else
      s_r <= s_nxt;
  end
endmodule
`default_nettype wire

// file: tb/sptc_serial_ctrl_sva.sv
// Purpose: port checks of the serial port control block
// Assumes: zero-wait APB, control word at 0x386c and 0x3c6c
// Notes: bound into every instance of the control block
`timescale 1ns/1ps
`default_nettype none
module sptc_serial_ctrl_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic txd_i,
  input wire logic txd_o,
  input wire logic txd_oe,
  input wire logic rxd_i,
  input wire logic txd_pin_owned,
  input wire logic rxd_pin_owned,
  input wire logic irq
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence ctrl_wr_s;
    psel && penable && pready && pwrite && (paddr == 16'h386c || paddr == 16'h3c6c);
  endsequence
  pready_first_a: assert property (setup_s |=> pready) else $error("pready late");
  pready_single_a: assert property (pready |=> !pready) else $error("pready held");
  bad_align_a: assert property (setup_s ##0 (paddr[1:0] != 2'h0) |=> pready && pslverr)
    else $error("unaligned access not refused");
  ctrl_map_a: assert property (setup_s ##0 (paddr == 16'h386c || paddr == 16'h3c6c)
    |=> pready && !pslverr) else $error("control word refused");
  oe_owned_a: assert property (txd_oe |-> txd_pin_owned) else $error("pin driven unowned");
  idle_high_a: assert property (!txd_pin_owned |-> txd_o) else $error("released line low");
  rx_release_a: assert property (ctrl_wr_s ##0 !pwdata[2] |-> ##2 !rxd_pin_owned)
    else $error("input pin kept");
  irq_mask_a: assert property (ctrl_wr_s ##0 (pwdata[7:4] == 4'h0) |-> ##2 !irq)
    else $error("masked interrupt raised");
  reset_line_a: assert property ($rose(presetn) |-> txd_o && !txd_oe)
    else $error("line not idle after reset");
endmodule
bind sptc_serial_ctrl sptc_serial_ctrl_sva sva_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .txd_i, .txd_o, .txd_oe, .rxd_i,
  .txd_pin_owned, .rxd_pin_owned, .irq);
`default_nettype wire

// file: tb/sptc_remote_node.sv
// Purpose: remote serial node on the transmit and receive lines
// Assumes: fixed bit time in pclk cycles, line idles high
// Notes: captured frames hold the stop bit above the data byte
`timescale 1ns/1ps
`default_nettype none
module sptc_remote_node #(parameter int BIT = 16) (
  input wire logic pclk,
  input wire logic line,
  output logic rxd
);
  // ----------------------------------------
  // sender and listener
  // ----------------------------------------
  logic [8:0] rx_q[$];
  logic [8:0] f;
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge pclk);
      rxd <= fr[i];
      repeat (BIT - 1) @(posedge pclk);
    end
  endtask
  always
  begin
    @(negedge line);
    repeat (BIT / 2) @(negedge pclk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BIT) @(negedge pclk);
      f[i] = line;
    end
    rx_q.push_back(f);
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Purpose: self-checking bench of the serial port control block
// Assumes: baud divisor 1, so one bit is 16 pclk cycles
// Notes: every scenario judges its own results
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ----------------------------------------
  // bench
  // ----------------------------------------
  localparam logic [15:0] CTRL = 16'h386c;
  localparam logic [15:0] CTRLN = 16'h3c6c;
  localparam logic [15:0] STAT = 16'h3870;
  localparam logic [15:0] DATA = 16'h387c;
  localparam logic [15:0] CTRL1 = 16'h3868;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, txd_o, txd_oe, txd_pin_owned, rxd_pin_owned, irq, err, rxd_i;
  wire line;
  int fails = 0;
  int checks = 0;
  int n;
  assign line = txd_oe ? txd_o : 1'b1;
  always #2.5 pclk = ~pclk;
  sptc_serial_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .txd_i(line), .txd_o, .txd_oe, .rxd_i, .txd_pin_owned,
    .rxd_pin_owned, .irq);
  sptc_remote_node node (.pclk, .line, .rxd(rxd_i));
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic hang(input string m);
    fails++;
    $display("wrong value at %0t: %s timed out", $time, m);
    end_of_test();
  endtask
  task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
      if (k > 20)
        hang("pready");
    end
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(q, e, "read data");
  endtask
  // s selects irq, txd_pin_owned or the line
  task automatic wait_on(input int s, input logic v, input int lim);
    int k;
    logic x;
    k = 0;
    do
    begin
      @(negedge pclk);
      x = (s == 0) ? irq : (s == 1) ? txd_pin_owned : line;
      k++;
      if (k > lim)
        hang("wait");
    end
    while (x !== v);
  endtask
  task automatic t_reset();
    rd(CTRL, 32'h0);
    rd(CTRLN, 32'h0);
    rd(STAT, 32'hc0);
    chk(irq, 1'b0, "irq after reset");
    rd(16'h3800, 32'h0);
    chk(err, 1'b1, "unmapped refused");
    rd(16'h386d, 32'h0);
    chk(err, 1'b1, "unaligned refused");
    $display("reset test done");
  endtask
  task automatic t_regs();
    apb(CTRL, 1'b1, 32'ha5);
    rd(CTRLN, 32'ha5);
    wait_on(0, 1'b1, 4);
    apb(CTRLN, 1'b1, 32'h0);
    wait_on(0, 1'b0, 4);
    apb(CTRL, 1'b1, 32'h40);
    wait_on(0, 1'b1, 4);
    chk(irq, 1'b1, "done irq");
    $display("register test done");
  endtask
  task automatic t_tx();
    apb(16'h3860, 1'b1, 32'h1);
    apb(CTRL, 1'b1, 32'h48);
    wait_on(0, 1'b0, 40);
    chk(txd_pin_owned, 1'b1, "pin owned");
    apb(DATA, 1'b1, 32'h35);
    wait_on(0, 1'b1, 800);
    chk(node.rx_q.size(), 1, "frame count");
    chk(node.rx_q.pop_front(), 9'h135, "frame");
    rd(STAT, 32'hc0);
    apb(DATA, 1'b1, 32'hc3);
    apb(CTRL, 1'b1, 32'h0);
    chk(txd_pin_owned, 1'b1, "pin kept");
    wait_on(1, 1'b0, 600);
    chk(node.rx_q.pop_front(), 9'h1c3, "last frame");
    apb(CTRL1, 1'b1, 32'h4);
    apb(CTRL, 1'b1, 32'h08);
    apb(DATA, 1'b1, 32'h1a5);
    apb(CTRL, 1'b1, 32'h0);
    wait_on(1, 1'b0, 800);
    chk(node.rx_q.pop_front(), 9'h1a5, "nine bit frame");
    $display("transmit test done");
  endtask
  task automatic t_break(input logic [31:0] c1, input int lo, input int hi, input bit hold);
    apb(CTRL1, 1'b1, c1);
    apb(CTRL, 1'b1, 32'h08);
    apb(CTRL, 1'b1, 32'h09);
    if (!hold)
      apb(CTRL, 1'b1, 32'h08);
    wait_on(2, 1'b0, 600);
    n = 0;
    while (line === 1'b0 && n < 500)
    begin
      @(negedge pclk);
      n++;
    end
    chk(n >= lo && n <= hi, 1'b1, "break length");
    apb(CTRL, 1'b1, 32'h0);
    wait_on(1, 1'b0, 800);
    node.rx_q.delete();
    $display("break test done");
  endtask
  task automatic t_rx();
    apb(CTRL1, 1'b1, 32'h0);
    apb(CTRL, 1'b1, 32'h24);
    repeat (2) @(negedge pclk);
    chk(rxd_pin_owned, 1'b1, "input owned");
    node.send(8'h5a);
    wait_on(0, 1'b1, 400);
    rd(DATA, 32'h5a);
    apb(CTRL, 1'b1, 32'h14);
    wait_on(0, 1'b1, 400);
    rd(STAT, 32'hd0);
    apb(CTRL1, 1'b1, 32'h20);
    repeat (2) @(negedge pclk);
    chk(rxd_pin_owned, 1'b0, "loop releases input");
    $display("receive test done");
  endtask
  task automatic t_wake();
    apb(CTRL1, 1'b1, 32'h02);
    apb(CTRL, 1'b1, 32'h06);
    node.send(8'h05);
    rd(CTRL, 32'h06);
    node.send(8'h85);
    rd(CTRL, 32'h04);
    rd(DATA, 32'h85);
    apb(CTRL1, 1'b1, 32'h00);
    repeat (200) @(negedge pclk);
    apb(CTRL, 1'b1, 32'h06);
    node.send(8'h85);
    rd(CTRL, 32'h06);
    repeat (200) @(negedge pclk);
    rd(CTRL, 32'h04);
    apb(CTRL1, 1'b1, 32'h28);
    apb(CTRL, 1'b1, 32'h08);
    repeat (2) @(negedge pclk);
    chk(txd_oe, 1'b0, "single line receive");
    apb(CTRL1, 1'b1, 32'h38);
    repeat (2) @(negedge pclk);
    chk(txd_oe, 1'b1, "single line transmit");
    $display("wake and single line test done");
  endtask
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_tx();
    t_break(32'h0, 160, 176, 1'b0);
    t_break(32'h1, 208, 224, 1'b0);
    t_break(32'h0, 500, 500, 1'b1);
    t_rx();
    t_wake();
    end_of_test();
  end
endmodule
`default_nettype wire
